// ### include/gptcc_pkg.sv
package gptcc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;

  // Register map, word addresses on the plain register port.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_CMP_A = 4'h2;
  localparam logic [3:0] ADDR_CMP_B = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;

  // Control register field positions.
  localparam int BIT_ENABLE = 15;
  localparam int BIT_PERMIT = 14;
  localparam int BIT_IRQ_EN = 13;
  localparam int BIT_B_IN_USE = 12;
  localparam int BIT_MAX_FLAG = 5;
  localparam int BIT_RETRIG = 4;
  localparam int BIT_PRESCALE = 3;
  localparam int BIT_EXTERNAL_CLOCK_SELECT = 2;
  localparam int BIT_ALTERNATE_COMPARE_SELECT = 1;
  localparam int BIT_CONT = 0;

  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CMP_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hffff;

  // Interrupt status bits.
  localparam int IRQ_BITS = 2;
  localparam int IRQ_MAX_A = 0;
  localparam int IRQ_MAX_B = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Internal clock advances the count every fourth core clock.
  localparam int INT_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(INT_DIV - 1);
  localparam logic [1:0] DIV_RESET = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } gptcc_req_t;

  typedef struct packed {
    logic enable;
    logic irq_enable;
    logic retrigger_select;
    logic prescale_select;
    logic external_clock_select;
    logic alternate_compare_select;
    logic continuous_select;
  } gptcc_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CMP_A = 3'b010,
    ST_CMP_B = 3'b100
  } gptcc_state_t;
endpackage : gptcc_pkg

// ### logic/gptcc_sync.sv
module gptcc_sync (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o,
  output logic rise_o
);
  import gptcc_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
  } gptcc_sync_t;

  gptcc_sync_t s_r;
  gptcc_sync_t s_nxt;

  always_comb begin
    s_nxt.meta = async_i;
    s_nxt.stable = s_r.meta;
    s_nxt.prev = s_r.stable;
  end

  // Reset to the high level so that a pin already high when reset ends is
  // not mistaken for a rising edge. A pin low at reset only opens the gate
  // for two cycles, while the timer is still disabled.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.stable;
  assign rise_o = s_r.stable & ~s_r.prev;
endmodule : gptcc_sync

// ### logic/gptcc_tick.sv
module gptcc_tick (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic tick_o
);
  import gptcc_pkg::*;

  typedef struct packed {
    logic [1:0] div;
  } gptcc_tick_st_t;

  gptcc_tick_st_t t_r;
  gptcc_tick_st_t t_nxt;

  // The divider holds while the timer is stopped so a restart resumes
  // exactly where it paused.
  always_comb begin
    t_nxt = t_r;
    if (run_i) begin
      t_nxt.div = (t_r.div == DIV_LAST) ? DIV_RESET : t_r.div + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      t_r.div <= DIV_RESET;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign tick_o = run_i && (t_r.div == DIV_LAST);
endmodule : gptcc_tick

// ### logic/gptcc_timer.sv
// Notes on behaviour
// (R1) Software writes zeros to bits 11..6.
// (R2) Reaching either maximum sets the max flag.
// (R3) Only a software zero write clears it.
// (R4) Alternate mode: flag on A or B, any enable.
// (R5) Gate mode: input high counts, low freezes.
// (R6) Retrigger: input rising edge clears the count.
// (R7) Retrigger ignored with external clock selected.
// (R8) Internal clock: one step every four cycles.
// (R9) Prescale: step on the prescaler timer's maximum.
// (R10) Prescale ignored with external clock selected.
// (R11) External clock: step on each input rise.
// (R12) External clock at most a quarter rate.
// (R13) Single mode: count to A, then zero.
// (R14) Single mode: output low one cycle after max.
// (R15) Alternate mode: A, zero, B, zero.
// (R16) Alternate mode: output high on A, low B.
// (R17) Noncontinuous: clear, halt, drop enable at end.
// (R18) Continuous: restart from zero immediately.
// (R19) Writing one to the max flag does nothing.
module gptcc_timer (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire gptcc_pkg::gptcc_req_t bus_i,
  output logic [gptcc_pkg::DATA_W-1:0] rdata_o,
  input wire logic timer_input_pin_i,
  input wire logic prescale_max_i,
  output logic timer_output_pin_o,
  output logic irq_o
);
  import gptcc_pkg::*;

  typedef struct packed {
    gptcc_cfg_t cfg;
    logic max_count_flag;
    gptcc_state_t state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_b;
    logic out_pin;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
  } gptcc_st_t;

  gptcc_st_t s_r;
  gptcc_st_t s_nxt;

  logic pin_level;
  logic pin_rise;
  logic int_tick;
  logic step;
  logic retrig_clear;
  logic [CNT_W-1:0] limit;
  logic at_limit;
  logic phase_b;
  logic wr_ctl;
  logic [DATA_W-1:0] ctl_view;
  logic [IRQ_BITS-1:0] irq_event;

  gptcc_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(timer_input_pin_i),
    .sync_o(pin_level),
    .rise_o(pin_rise)
  );

  // The internal divider runs only while the gate lets the count move.
  gptcc_tick u_tick (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(s_r.cfg.enable && (s_r.cfg.retrigger_select || pin_level)), // [R5]
    .tick_o(int_tick)
  );

  always_comb begin
    if (s_r.cfg.external_clock_select) begin
      step = pin_rise; // [R11] [R10] [R12]
    end else if (s_r.cfg.prescale_select) begin
      // Gate level still applies to prescaled counting.
      step = prescale_max_i &&
             (s_r.cfg.retrigger_select || pin_level); // [R9] [R5]
    end else begin
      step = int_tick; // [R8]
    end
    step = step && s_r.cfg.enable;
  end

  assign retrig_clear = s_r.cfg.enable && s_r.cfg.retrigger_select &&
                        !s_r.cfg.external_clock_select && pin_rise; // [R6] [R7]

  assign phase_b = s_r.cfg.alternate_compare_select &&
                   (s_r.state == ST_CMP_B);
  // A zero compare value is taken as 16'hffff, a span of 65535 steps.
  always_comb begin
    limit = phase_b ? s_r.cmp_b : s_r.cmp_a;
    if (limit == CMP_ZERO) begin
      limit = COUNT_FULL;
    end
  end
  assign at_limit = step && (s_r.count + 16'h0001 == limit);

  assign wr_ctl = bus_i.wr && (bus_i.addr == ADDR_CONTROL);

  always_comb begin
    ctl_view = '0; // [R1]
    ctl_view[BIT_ENABLE] = s_r.cfg.enable;
    ctl_view[BIT_IRQ_EN] = s_r.cfg.irq_enable;
    ctl_view[BIT_B_IN_USE] = phase_b;
    ctl_view[BIT_MAX_FLAG] = s_r.max_count_flag;
    ctl_view[BIT_RETRIG] = s_r.cfg.retrigger_select;
    ctl_view[BIT_PRESCALE] = s_r.cfg.prescale_select;
    ctl_view[BIT_EXTERNAL_CLOCK_SELECT] = s_r.cfg.external_clock_select;
    ctl_view[BIT_ALTERNATE_COMPARE_SELECT] = s_r.cfg.alternate_compare_select;
    ctl_view[BIT_CONT] = s_r.cfg.continuous_select;
  end

  always_comb begin
    irq_event = '0;
    if (at_limit && s_r.cfg.irq_enable) begin
      irq_event[IRQ_MAX_A] = !phase_b;
      irq_event[IRQ_MAX_B] = phase_b;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.out_pin = 1'b1;

    // Software writes.
    if (wr_ctl) begin
      if (bus_i.wdata[BIT_PERMIT]) begin
        s_nxt.cfg.enable = bus_i.wdata[BIT_ENABLE];
      end
      s_nxt.cfg.irq_enable = bus_i.wdata[BIT_IRQ_EN];
      s_nxt.cfg.retrigger_select = bus_i.wdata[BIT_RETRIG];
      s_nxt.cfg.prescale_select = bus_i.wdata[BIT_PRESCALE];
      s_nxt.cfg.external_clock_select = bus_i.wdata[BIT_EXTERNAL_CLOCK_SELECT];
      s_nxt.cfg.alternate_compare_select = bus_i.wdata[BIT_ALTERNATE_COMPARE_SELECT];
      s_nxt.cfg.continuous_select = bus_i.wdata[BIT_CONT];
      if (!bus_i.wdata[BIT_MAX_FLAG]) begin
        s_nxt.max_count_flag = 1'b0; // [R3] [R19]
      end
    end
    if (bus_i.wr && bus_i.addr == ADDR_COUNT) begin
      s_nxt.count = bus_i.wdata;
    end
    if (bus_i.wr && bus_i.addr == ADDR_CMP_A) begin
      s_nxt.cmp_a = bus_i.wdata;
    end
    if (bus_i.wr && bus_i.addr == ADDR_CMP_B) begin
      s_nxt.cmp_b = bus_i.wdata;
    end
    if (bus_i.wr && bus_i.addr == ADDR_IRQ_STATUS) begin
      s_nxt.irq_status = s_r.irq_status & ~bus_i.wdata[IRQ_BITS-1:0];
    end
    if (bus_i.wr && bus_i.addr == ADDR_IRQ_MASK) begin
      s_nxt.irq_mask = bus_i.wdata[IRQ_BITS-1:0];
    end

    // Counting; hardware wins over a same-cycle software write.
    if (s_r.cfg.enable && s_r.state == ST_IDLE) begin
      s_nxt.state = ST_CMP_A;
    end
    if (retrig_clear) begin
      s_nxt.count = COUNT_RESET; // [R6]
    end else if (at_limit) begin
      s_nxt.count = COUNT_RESET; // [R13] [R18]
      s_nxt.max_count_flag = 1'b1; // [R2] [R4]
      if (!s_r.cfg.alternate_compare_select) begin
        s_nxt.out_pin = 1'b0; // [R14]
        s_nxt.state = ST_CMP_A;
      end else begin
        s_nxt.state = phase_b ? ST_CMP_A : ST_CMP_B; // [R15]
      end
      if (!s_r.cfg.continuous_select &&
          (!s_r.cfg.alternate_compare_select || phase_b)) begin
        s_nxt.cfg.enable = 1'b0; // [R17]
        s_nxt.state = ST_IDLE;
      end
    end else if (step) begin
      s_nxt.count = s_r.count + 16'h0001;
    end

    if (s_r.cfg.alternate_compare_select) begin
      s_nxt.out_pin = !(s_nxt.state == ST_CMP_B); // [R16]
    end

    s_nxt.irq_status = s_nxt.irq_status | irq_event;

    s_nxt.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_CONTROL: s_nxt.rdata = ctl_view;
        ADDR_COUNT: s_nxt.rdata = s_r.count;
        ADDR_CMP_A: s_nxt.rdata = s_r.cmp_a;
        ADDR_CMP_B: s_nxt.rdata = s_r.cmp_b;
        ADDR_IRQ_STATUS: s_nxt.rdata = {14'h0000, s_r.irq_status};
        ADDR_IRQ_MASK: s_nxt.rdata = {14'h0000, s_r.irq_mask};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r.cfg <= '0;
      s_r.max_count_flag <= 1'b0;
      s_r.state <= ST_IDLE;
      s_r.count <= COUNT_RESET;
      s_r.cmp_a <= CMP_RESET;
      s_r.cmp_b <= CMP_RESET;
      s_r.out_pin <= 1'b1;
      s_r.irq_status <= IRQ_RESET;
      s_r.irq_mask <= IRQ_RESET;
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign timer_output_pin_o = s_r.out_pin;
  assign irq_o = |(s_r.irq_status & s_r.irq_mask);
endmodule : gptcc_timer

// ### sim/gptcc_pin_model.sv
module gptcc_pin_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] mode_i,
  output logic pin_o,
  output logic psc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
    end
  end
  // Modes 0 and 1 hold the pin still; 2 clocks at 1/8 rate, 3 at 1/4.
  assign pin_o = mode_i[1] ? (mode_i[0] ? ph_r[1] : ph_r[2]) : mode_i[0];
  assign psc_o = (ph_r == 3'h7);
endmodule : gptcc_pin_model

// ### sim/gptcc_properties.sv
module gptcc_properties (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire gptcc_pkg::gptcc_req_t bus_i,
  input wire logic [gptcc_pkg::DATA_W-1:0] rdata_o,
  input wire logic timer_input_pin_i,
  input wire logic prescale_max_i,
  input wire logic timer_output_pin_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gptcc_pkg::*;
  logic [15:0] cfg_r;
  logic [1:0] mask_r;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // The control shadow holds whole written words and the mask shadow only bits 1..0; the checks use only bits that the timer never changes itself.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_r <= '0;
      mask_r <= '0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == ADDR_CONTROL) cfg_r <= bus_i.wdata;
      if (bus_i.addr == ADDR_IRQ_MASK) mask_r <= bus_i.wdata[1:0];
    end
  end
  // Eight quiet cycles cover the pin synchroniser and the output register.
  sequence pin_quiet;
    !timer_input_pin_i [*8];
  endsequence
  sequence low_blip;
    $fell(timer_output_pin_o) ##1 timer_output_pin_o;
  endsequence
  chk_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
    else $error("read data outside answer cycle");
  chk_unmapped_read_zero: assert property ($past(bus_i.rd) &&
    $past(bus_i.addr) > ADDR_IRQ_MASK |-> rdata_o == '0)
    else $error("unmapped read not zero");
  chk_control_readback: assert property ($past(bus_i.rd) &&
    $past(bus_i.addr) == ADDR_CONTROL |->
    !rdata_o[BIT_PERMIT] && rdata_o[11:6] == '0)
    else $error("control read shows permit or reserved bits");
  chk_single_pulse: assert property (
    !cfg_r[BIT_ALTERNATE_COMPARE_SELECT] && $fell(timer_output_pin_o) |-> low_blip)
    else $error("single mode low pulse not one cycle");
  chk_pulse_spacing: assert property (
    !cfg_r[BIT_ALTERNATE_COMPARE_SELECT] && $fell(timer_output_pin_o) |=>
    (!$fell(timer_output_pin_o)) [*3])
    else $error("count steps faster than a quarter rate");
  chk_frozen_output: assert property (
    pin_quiet ##0 (cfg_r[BIT_EXTERNAL_CLOCK_SELECT] || !cfg_r[BIT_RETRIG]) |->
    $stable(timer_output_pin_o))
    else $error("output moved with the count frozen");
  chk_mask_gate: assert property ($past(mask_r) == '0 && mask_r == '0
    |-> !irq_o)
    else $error("interrupt with all sources masked");
  chk_reset_levels: assert property ($rose(rst_n_i) |->
    timer_output_pin_o && !irq_o)
    else $error("pin levels wrong after reset");
endmodule : gptcc_properties

bind gptcc_timer gptcc_properties u_props (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .bus_i(bus_i),
  .rdata_o(rdata_o),
  .timer_input_pin_i(timer_input_pin_i),
  .prescale_max_i(prescale_max_i),
  .timer_output_pin_o(timer_output_pin_o),
  .irq_o(irq_o)
);

// ### sim/gptcc_timer_test.sv
module gptcc_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gptcc_pkg::*;
  typedef struct packed {
    logic [3:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } gptcc_row_t;
  localparam gptcc_row_t ROWS [6] = '{'{ADDR_CMP_A, 16'h1234, 16'h1234},
    '{ADDR_CMP_B, 16'hffff, 16'hffff}, '{ADDR_IRQ_MASK, 16'h0003, 16'h0003},
    '{ADDR_COUNT, 16'h0042, 16'h0042}, '{4'h9, 16'h5555, 16'h0000},
    '{ADDR_CONTROL, 16'h603f, 16'h201f}};
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  gptcc_req_t bus = '0;
  logic [1:0] mode = 2'h1;
  logic [15:0] rdata, v, w;
  logic pin, psc, out, irq, outq, pinq;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0, nf = 0, nr = 0, tf = 0, tr = 0, t = 0, rises = 0;
  gptcc_timer dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
    .rdata_o(rdata), .timer_input_pin_i(pin), .prescale_max_i(psc),
    .timer_output_pin_o(out), .irq_o(irq));
  gptcc_pin_model pm (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .mode_i(mode), .pin_o(pin), .psc_o(psc));
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) cyc++;
  // Edges are logged at the falling clock edge, clear of the update races.
  always @(negedge core_clk_i) begin
    if (outq === 1'b1 && out === 1'b0) begin
      nf++;
      tf = cyc;
    end
    if (outq === 1'b0 && out === 1'b1) begin
      nr++;
      tr = cyc;
    end
    if (pin === 1'b1 && pinq === 1'b0) rises++;
    outq = out;
    pinq = pin;
  end
  task complete_run();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task hold(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : hold
  task rst();
    rst_n_i <= 1'b0;
    hold(6);
    rst_n_i <= 1'b1;
    hold(1);
  endtask : rst
  task wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    hold(1);
    bus <= '0;
    hold(1);
  endtask : wr
  task rd(input logic [3:0] a, output logic [15:0] d);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    hold(1);
    bus <= '0;
    @(negedge core_clk_i);
    d = rdata;
    hold(1);
  endtask : rd
  task rdc(input logic [3:0] a, input logic [15:0] e);
    rd(a, v);
    chk(v, e);
  endtask : rdc
  task chk_irq(input logic e);
    @(negedge core_clk_i);
    chk({15'h0000, irq}, {15'h0000, e});
    hold(1);
  endtask : chk_irq
  task wait_ev(input logic rise);
    int base;
    base = rise ? nr : nf;
    for (int i = 0; i < 600 && (rise ? nr : nf) == base; i++) hold(1);
    if ((rise ? nr : nf) == base) begin
      error_cnt++;
      $display("wrong value at %0t: output edge missing", $time);
      complete_run();
    end
  endtask : wait_ev
  initial begin
    rst();
    rdc(ADDR_CONTROL, CONTROL_RESET);
    rdc(ADDR_IRQ_STATUS, {14'h0000, IRQ_RESET});
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rdc(ROWS[i].a, ROWS[i].e);
    end
    wr(ADDR_CMP_A, 16'h0003);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_CONTROL, 16'he001);
    wait_ev(1'b0);
    t = tf;
    wait_ev(1'b0);
    chk(16'(tf - t), 16'h000c);
    wait_ev(1'b1);
    chk(16'(tr - tf), 16'h0001);
    rdc(ADDR_IRQ_STATUS, 16'h0001);
    chk_irq(1'b1);
    wr(ADDR_IRQ_MASK, 16'h0000);
    chk_irq(1'b0);
    wr(ADDR_IRQ_MASK, 16'h0001);
    chk_irq(1'b1);
    wr(ADDR_CONTROL, 16'h6021);
    hold(20);
    rdc(ADDR_CONTROL, 16'h2021);
    wr(ADDR_CONTROL, 16'h2001);
    rdc(ADDR_CONTROL, 16'h2001);
    wr(ADDR_IRQ_STATUS, 16'h0003);
    rdc(ADDR_IRQ_STATUS, 16'h0000);
    chk_irq(1'b0);
    rst();
    mode <= 2'h0;
    wr(ADDR_CONTROL, 16'hc001);
    hold(20);
    rd(ADDR_COUNT, w);
    chk(w, COUNT_RESET);
    hold(20);
    rdc(ADDR_COUNT, w);
    mode <= 2'h1;
    hold(20);
    rd(ADDR_COUNT, v);
    chk(16'(v > w), 16'h0001);
    wr(ADDR_CONTROL, 16'h0011);
    hold(40);
    mode <= 2'h0;
    hold(8);
    mode <= 2'h1;
    hold(6);
    rd(ADDR_COUNT, w);
    chk(16'(w < 16'h0003), 16'h0001);
    rst();
    mode <= 2'h0;
    wr(ADDR_CONTROL, 16'hc01d);
    rises = 0;
    mode <= 2'h3;
    hold(40);
    mode <= 2'h0;
    hold(8);
    rdc(ADDR_COUNT, 16'(rises));
    rst();
    mode <= 2'h1;
    wr(ADDR_CONTROL, 16'hc009);
    hold(64);
    wr(ADDR_CONTROL, 16'h4009);
    rd(ADDR_COUNT, w);
    chk(16'(w >= 16'h0007 && w <= 16'h0009), 16'h0001);
    rst();
    wr(ADDR_CMP_A, 16'h0002);
    wr(ADDR_CMP_B, 16'h0003);
    wr(ADDR_CONTROL, 16'hc003);
    wait_ev(1'b0);
    wait_ev(1'b1);
    chk(16'(tr - tf), 16'h000c);
    wait_ev(1'b0);
    chk(16'(tf - tr), 16'h0008);
    wr(ADDR_CONTROL, 16'h0002);
    hold(30);
    rdc(ADDR_CONTROL, 16'h0022);
    rdc(ADDR_COUNT, 16'h0000);
    complete_run();
  end
endmodule : gptcc_timer_test
